// >>> hdl/slk_drive_port.sv
// media drive end of the serial automation link
// Functional notes
// [R1] parameter change recomputes ack time-out (the ip variant keeps its fixed time-out instead)
// [R2] new time-out applies to later frames
// [R3] ip variant starts at 2500 ms time-out
// [R4] link runs at 9600 baud (code: only until login, then at the negotiated rate)
// [R5] nrz, one bit per baud period
// [R6] one start, eight data, one stop
// [R7] reset request means reset received
// [R8] automation may request reset, optional
// [R9] automation presence line driven by automation
// [R10] drive watches automation presence
// [R11] automation may watch drive presence
// [R12] default 9600 until login completes
// [R13] presence loss raises nexus-loss event
// [R14] reset received raises nexus-loss event
// [R15] timer starts at frame end, flags time-out
// [R16] time-out formula is parameterised
`timescale 1ns/1ps
`default_nettype none
module slk_drive_port #(
	parameter bit                      IP_VARIANT = 1'b0,
	parameter int unsigned             ACK_BITS   = slk_pkg::ACK_BITS_DEF,
	parameter logic [slk_pkg::TMO_W-1:0] IP_ACK_CYC =
		slk_pkg::TMO_W'(slk_pkg::IP_ACK_CYC)
) (
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       reset_i,
	// link
	slk_if.drive                            link,
	// operating parameters
	input  wire logic                       login_done_i,
	input  wire logic [slk_pkg::DIV_W-1:0]  neg_bit_cyc_i,
	input  wire logic                       param_load_i,
	// transmit
	input  wire logic                       tx_valid_i,
	input  wire logic [slk_pkg::DATA_W-1:0] tx_data_i,
	output logic                            tx_ready_o,
	input  wire logic                       ack_seen_i,
	output logic                            ack_timeout_o,
	// receive
	output logic                            rx_valid_o,
	output logic [slk_pkg::DATA_W-1:0]      rx_data_o,
	output logic                            rx_err_o,
	// events
	output logic                            aut_present_o,
	output logic                            reset_rcvd_o,
	output logic                            nexus_loss_o
);
	logic [slk_pkg::DIV_W-1:0] bit_cyc_ff;
	logic [slk_pkg::TMO_W-1:0] tmo_ff, tcnt_ff;
	logic                      run_ff, sense_ff, rst_ff, tx_done;
	logic                      recalc_ff;

	assign link.sense_drv = 1'b1;

	// 9600 default until login, negotiated rate after
	always_ff @(posedge clk_i) begin // see [R4] see [R12]
		recalc_ff <= 1'b0;
		if (reset_i || !login_done_i) begin
			recalc_ff  <= bit_cyc_ff !=
				slk_pkg::DIV_W'(slk_pkg::BIT_CYC_DEF);
			bit_cyc_ff <= slk_pkg::DIV_W'(slk_pkg::BIT_CYC_DEF);
		end else if (param_load_i) begin
			bit_cyc_ff <= neg_bit_cyc_i;
			recalc_ff  <= 1'b1;
		end
	end

	// time-out recomputed from rate on every parameter change, except in the ip variant
	always_ff @(posedge clk_i) begin // see [R1] see [R16] see [R3]
		if (reset_i)
			tmo_ff <= IP_VARIANT ? IP_ACK_CYC :
				slk_pkg::TMO_W'(ACK_BITS * slk_pkg::BIT_CYC_DEF);
		else if (recalc_ff && !IP_VARIANT)
			tmo_ff <= slk_pkg::TMO_W'(ACK_BITS) * {16'h0, bit_cyc_ff};
	end

	slk_uart u_uart (
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.bit_cyc_i  (bit_cyc_ff),
		.tx_valid_i (tx_valid_i),
		.tx_data_i  (tx_data_i),
		.tx_ready_o (tx_ready_o),
		.tx_done_o  (tx_done),
		.txd_o      (link.drv_txd),
		.rxd_i      (link.aut_txd),
		.rx_valid_o (rx_valid_o),
		.rx_data_o  (rx_data_o),
		.rx_err_o   (rx_err_o)
	);

	// ack timer armed at frame end with current period
	always_ff @(posedge clk_i) begin // see [R15] see [R2]
		ack_timeout_o <= 1'b0;
		if (reset_i || ack_seen_i) begin
			run_ff  <= 1'b0;
			tcnt_ff <= '0;
		end else if (tx_done) begin
			run_ff  <= 1'b1;
			tcnt_ff <= tmo_ff;
		end else if (run_ff) begin
			if (tcnt_ff <= 32'h1) begin
				run_ff        <= 1'b0;
				ack_timeout_o <= 1'b1;
			end else begin
				tcnt_ff <= tcnt_ff - 32'h1;
			end
		end
	end

	// presence and reset request events
	always_ff @(posedge clk_i) begin // see [R10] see [R7]
		if (reset_i) begin
			sense_ff      <= 1'b0;
			rst_ff        <= 1'b0;
			aut_present_o <= 1'b0;
			reset_rcvd_o  <= 1'b0;
			nexus_loss_o  <= 1'b0;
		end else begin
			sense_ff      <= link.sense_aut;
			rst_ff        <= link.reset_req;
			aut_present_o <= link.sense_aut;
			reset_rcvd_o  <= link.reset_req && !rst_ff;
			nexus_loss_o  <= (sense_ff && !link.sense_aut) || // see [R13]
				(link.reset_req && !rst_ff); // see [R14]
		end
	end
endmodule
`default_nettype wire

// >>> hdl/slk_pkg.sv
// shared constants for the serial automation port link
package slk_pkg;
	localparam int unsigned CLK_HZ        = 20000000;
	localparam int unsigned BAUD_DEFAULT  = 9600;
	localparam int unsigned BIT_CYC_DEF   = CLK_HZ / BAUD_DEFAULT;
	localparam int unsigned DIV_W         = 16;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned FRAME_BITS    = 10;
	// ack time-out figure: bit periods per timeout at a given rate
	localparam int unsigned ACK_BITS_DEF  = 2000;
	localparam int unsigned IP_ACK_MS     = 2500;
	localparam int unsigned IP_ACK_CYC    = IP_ACK_MS * (CLK_HZ / 1000);
	localparam int unsigned TMO_W         = 32;
	localparam logic        LINE_IDLE     = 1'b1;
	localparam logic        START_LVL     = 1'b0;
	localparam logic        STOP_LVL      = 1'b1;
endpackage

// >>> hdl/slk_if.sv
// link between media drive port and automation port
`timescale 1ns/1ps
`default_nettype none
interface slk_if;
	logic drv_txd;       // drive to automation serial line
	logic aut_txd;       // automation to drive serial line
	logic sense_aut;     // automation presence, high = present
	logic sense_drv;     // drive presence, high = present
	logic reset_req;     // automation reset request, high = active
	modport drive (output drv_txd, output sense_drv,
		input aut_txd, input sense_aut, input reset_req);
	modport automation (input drv_txd, input sense_drv,
		output aut_txd, output sense_aut, output reset_req);
endinterface
`default_nettype wire

// >>> hdl/slk_uart.sv
// shared nrz 8n1 transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
module slk_uart (
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       reset_i,
	input  wire logic [slk_pkg::DIV_W-1:0]  bit_cyc_i,
	// transmit
	input  wire logic                       tx_valid_i,
	input  wire logic [slk_pkg::DATA_W-1:0] tx_data_i,
	output logic                            tx_ready_o,
	output logic                            tx_done_o,
	output logic                            txd_o,
	// receive
	input  wire logic                       rxd_i,
	output logic                            rx_valid_o,
	output logic [slk_pkg::DATA_W-1:0]      rx_data_o,
	output logic                            rx_err_o
);
	logic [slk_pkg::DIV_W-1:0] tdiv_ff, rdiv_ff;
	logic [3:0]                tcnt_ff, rcnt_ff;
	logic [9:0]                tsh_ff;
	logic [8:0]                rsh_ff;
	logic                      tbusy_ff, rbusy_ff, rxq_ff;

	assign tx_ready_o = !tbusy_ff;

	// one bit per baud period, start + 8 data + stop, no parity
	always_ff @(posedge clk_i) begin // see [R5] see [R6]
		tx_done_o <= 1'b0;
		if (reset_i) begin
			tbusy_ff <= 1'b0;
			tsh_ff   <= '1;
			tdiv_ff  <= '0;
			tcnt_ff  <= '0;
			txd_o    <= slk_pkg::LINE_IDLE;
		end else if (!tbusy_ff) begin
			txd_o <= slk_pkg::LINE_IDLE;
			if (tx_valid_i) begin
				tsh_ff   <= {slk_pkg::STOP_LVL, tx_data_i,
					slk_pkg::START_LVL};
				tbusy_ff <= 1'b1;
				tdiv_ff  <= '0;
				tcnt_ff  <= '0;
			end
		end else begin
			txd_o <= tsh_ff[0];
			if (tdiv_ff == bit_cyc_i - 16'h1) begin
				tdiv_ff <= '0;
				tsh_ff  <= {1'b1, tsh_ff[9:1]};
				if (tcnt_ff == 4'(slk_pkg::FRAME_BITS - 1)) begin
					tbusy_ff  <= 1'b0;
					tx_done_o <= 1'b1;
				end else begin
					tcnt_ff <= tcnt_ff + 4'h1;
				end
			end else begin
				tdiv_ff <= tdiv_ff + 16'h1;
			end
		end
	end

	// receiver samples mid-bit
	always_ff @(posedge clk_i) begin // see [R5] see [R6]
		rx_valid_o <= 1'b0;
		rx_err_o   <= 1'b0;
		rxq_ff     <= rxd_i;
		if (reset_i) begin
			rbusy_ff  <= 1'b0;
			rdiv_ff   <= '0;
			rcnt_ff   <= '0;
			rsh_ff    <= '0;
			rx_data_o <= '0;
			rxq_ff    <= slk_pkg::LINE_IDLE;
		end else if (!rbusy_ff) begin
			if (rxq_ff == slk_pkg::START_LVL) begin
				rbusy_ff <= 1'b1;
				rdiv_ff  <= {1'b0, bit_cyc_i[slk_pkg::DIV_W-1:1]};
				rcnt_ff  <= '0;
			end
		end else if (rdiv_ff == bit_cyc_i - 16'h1) begin
			rdiv_ff <= '0;
			rsh_ff  <= {rxq_ff, rsh_ff[8:1]};
			if (rcnt_ff == 4'(slk_pkg::FRAME_BITS - 1)) begin
				rbusy_ff <= 1'b0;
				if (rxq_ff == slk_pkg::STOP_LVL) begin
					rx_valid_o <= 1'b1;
					rx_data_o  <= rsh_ff[8:1];
				end else begin
					rx_err_o <= 1'b1;
				end
			end else begin
				rcnt_ff <= rcnt_ff + 4'h1;
			end
		end else begin
			rdiv_ff <= rdiv_ff + 16'h1;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/slk_auto_port.sv
// automation end of the serial automation link
`timescale 1ns/1ps
`default_nettype none
module slk_auto_port (
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       reset_i,
	// link
	slk_if.automation                       link,
	// control
	input  wire logic [slk_pkg::DIV_W-1:0]  bit_cyc_i,
	input  wire logic                       reset_req_i,
	output logic                            drv_present_o,
	// transmit
	input  wire logic                       tx_valid_i,
	input  wire logic [slk_pkg::DATA_W-1:0] tx_data_i,
	output logic                            tx_ready_o,
	// receive
	output logic                            rx_valid_o,
	output logic [slk_pkg::DATA_W-1:0]      rx_data_o,
	output logic                            rx_err_o
);
	logic rst_ff;

	assign link.sense_aut = 1'b1; // see [R9]
	assign link.reset_req = rst_ff;

	// reset request and drive presence
	always_ff @(posedge clk_i) begin // see [R8] see [R11]
		if (reset_i) begin
			rst_ff        <= 1'b0;
			drv_present_o <= 1'b0;
		end else begin
			rst_ff        <= reset_req_i;
			drv_present_o <= link.sense_drv;
		end
	end

	slk_uart u_uart (
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.bit_cyc_i  (bit_cyc_i),
		.tx_valid_i (tx_valid_i),
		.tx_data_i  (tx_data_i),
		.tx_ready_o (tx_ready_o),
		.tx_done_o  (),
		.txd_o      (link.aut_txd),
		.rxd_i      (link.drv_txd),
		.rx_valid_o (rx_valid_o),
		.rx_data_o  (rx_data_o),
		.rx_err_o   (rx_err_o)
	); // see [R4] see [R5] see [R6]
endmodule
`default_nettype wire

// >>> test/slk_link_properties.sv
// wire-level checks on the serial automation link
`timescale 1ns/1ps
`default_nettype none
module slk_link_properties (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_i,
	// link wires
	input  wire logic drv_txd,
	input  wire logic aut_txd,
	input  wire logic sense_aut,
	input  wire logic sense_drv,
	input  wire logic reset_req
);
	localparam int LOW_MAX = 18767;
	logic [15:0]   low_cnt_ff;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// longest legal low run is a zero byte at the default rate
	always_ff @(posedge clk_i) begin
		if (reset_i || drv_txd)
			low_cnt_ff <= 16'h0000;
		else if (low_cnt_ff != 16'hffff)
			low_cnt_ff <= low_cnt_ff + 16'h0001;
	end
	a_idle_after_rst: assert property (
		$fell(reset_i) |-> drv_txd && aut_txd && !reset_req)
		else $error("link not idle after reset");
	a_sense_aut_on: assert property (
		!$past(reset_i) |-> sense_aut)
		else $error("automation presence low");
	a_sense_drv_on: assert property (
		!$past(reset_i) |-> sense_drv)
		else $error("drive presence low");
	a_drv_fall_hold: assert property (
		$fell(drv_txd) |-> !drv_txd [*8])
		else $error("drive line low under one bit");
	a_drv_rise_hold: assert property (
		$rose(drv_txd) |-> drv_txd [*8])
		else $error("drive line high under one bit");
	a_aut_fall_hold: assert property (
		$fell(aut_txd) |-> !aut_txd [*8])
		else $error("automation line low under one bit");
	a_aut_rise_hold: assert property (
		$rose(aut_txd) |-> aut_txd [*8])
		else $error("automation line high under one bit");
	a_drv_low_max: assert property (
		low_cnt_ff < 16'(LOW_MAX))
		else $error("drive line low past a frame");
endmodule
`default_nettype wire

// >>> test/tb.sv
// self-checking bench joining the drive and automation ends
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int ACK = 4;
	localparam int IP_T = 400;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        login_done = 1'b0;
	logic        param_load = 1'b0;
	logic        rst_req = 1'b0;
	logic        ack_seen = 1'b0;
	logic [15:0] neg_bit = 16'h0010;
	logic [15:0] a_bit = 16'h0823;
	logic        tx_v[2] = '{1'b0, 1'b0};
	logic [7:0]  tx_d[2] = '{8'h00, 8'h00};
	logic        tx_r[2], rx_v[2], rx_e[2];
	logic [7:0]  rx_d[2];
	logic        tmo, rcvd, nex, pres, dpres, err2, nex2, pres2, rxv2;
	logic        tx_v2 = 1'b0, tmo2;
	logic [9:0]  fr;
	logic [7:0]  rq[2][$];
	int          miscompares = 0, num_checks = 0, seed = 98;
	int          cyc = 0, t0, m, k, g, tmo_at = 0, n_tmo = 0, n_rcvd = 0;
	int          n_nex = 0, n_err = 0, n_nex2 = 0, n_err2 = 0, n_rx2 = 0;
	int          tmo2_at = 0;
	slk_if link ();
	slk_if link2 ();
	slk_drive_port #(.ACK_BITS(ACK)) slk_drive_port_i (.clk_i, .reset_i,
		.link(link.drive), .login_done_i(login_done),
		.neg_bit_cyc_i(neg_bit), .param_load_i(param_load),
		.tx_valid_i(tx_v[0]), .tx_data_i(tx_d[0]), .tx_ready_o(tx_r[0]),
		.ack_seen_i(ack_seen), .ack_timeout_o(tmo), .rx_valid_o(rx_v[0]),
		.rx_data_o(rx_d[0]), .rx_err_o(rx_e[0]), .aut_present_o(pres),
		.reset_rcvd_o(rcvd), .nexus_loss_o(nex));
	slk_drive_port #(.ACK_BITS(ACK), .IP_VARIANT(1'b1),
		.IP_ACK_CYC(32'(IP_T))) slk_drive_port_x_i (.clk_i, .reset_i,
		.link(link2.drive), .login_done_i(login_done),
		.neg_bit_cyc_i(neg_bit), .param_load_i(param_load),
		.tx_valid_i(tx_v2), .tx_data_i(8'h00), .tx_ready_o(),
		.ack_seen_i(1'b0), .ack_timeout_o(tmo2), .rx_valid_o(rxv2),
		.rx_data_o(), .rx_err_o(err2), .aut_present_o(pres2),
		.reset_rcvd_o(), .nexus_loss_o(nex2));
	slk_auto_port slk_auto_port_i (.clk_i, .reset_i, .link(link.automation),
		.bit_cyc_i(a_bit), .reset_req_i(rst_req), .drv_present_o(dpres),
		.tx_valid_i(tx_v[1]), .tx_data_i(tx_d[1]), .tx_ready_o(tx_r[1]),
		.rx_valid_o(rx_v[1]), .rx_data_o(rx_d[1]), .rx_err_o(rx_e[1]));
	slk_link_properties slk_link_properties_i (.clk_i, .reset_i,
		.drv_txd(link.drv_txd), .aut_txd(link.aut_txd),
		.sense_aut(link.sense_aut), .sense_drv(link.sense_drv),
		.reset_req(link.reset_req));
	always #25 clk_i = ~clk_i;
	task automatic check(input string what, input logic [31:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			$display("BAD %s expected %0h seen %0h", what, exp, got);
			miscompares++;
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	function automatic logic [9:0] frame(input logic [7:0] d, input logic s);
		return {s, d, 1'b0};
	endfunction
	// cycles from byte taken to ack time-out seen, timer of t cycles
	function automatic int exp_gap(input int b, input int t);
		return slk_pkg::FRAME_BITS * b + t + 2;
	endfunction
	// send on side s, then expect the byte at the other end
	task automatic xfer(input int s, input logic [7:0] d);
		int n;
		n = 0;
		while (tx_r[s] !== 1'b1 && n++ < 30000)
			tick(1);
		tx_d[s] = d;
		tx_v[s] = 1'b1;
		tick(1);
		tx_v[s] = 1'b0;
		t0 = cyc;
		n = 0;
		while (rq[1-s].size() == 0 && n++ < 30000)
			tick(1);
		check("rx byte", 32'(d),
			n < 30000 ? 32'(rq[1-s].pop_front()) : 'x);
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (rx_v[0] === 1'b1)
			rq[0].push_back(rx_d[0]);
		if (rx_v[1] === 1'b1)
			rq[1].push_back(rx_d[1]);
		if (tmo === 1'b1)
			tmo_at = cyc;
		if (tmo2 === 1'b1)
			tmo2_at = cyc;
		n_tmo += (tmo === 1'b1);
		n_rcvd += (rcvd === 1'b1);
		n_nex += (nex === 1'b1);
		n_err += (rx_e[0] === 1'b1 || rx_e[1] === 1'b1);
		n_nex2 += (nex2 === 1'b1);
		n_err2 += (err2 === 1'b1);
		n_rx2 += (rxv2 === 1'b1);
		if (cyc == 60000) begin
			miscompares++;
			close_out();
		end
	end
	initial begin
		link2.aut_txd = 1'b1;
		link2.sense_aut = 1'b1;
		link2.reset_req = 1'b0;
		tick(12);
		reset_i = 1'b0;
		tick(2);
		param_load = 1'b1;
		tick(1);
		param_load = 1'b0;
		xfer(0, 8'ha5);
		xfer(1, 8'h3c);
		// let the last stop bit finish before the rate moves
		tick(slk_pkg::BIT_CYC_DEF);
		login_done = 1'b1;
		for (int b = 16; b <= 32; b += 16) begin
			neg_bit = 16'(b);
			a_bit = 16'(b);
			param_load = 1'b1;
			tick(1);
			param_load = 1'b0;
			for (int i = 0; i < 8; i++)
				xfer(i % 2, i < 4 ? {8{i[1]}} : 8'($random(seed)));
			xfer(0, 8'(b));
			tick(exp_gap(b, ACK * b) + 8);
			g = tmo_at - t0;
			check("ack gap", exp_gap(b, ACK * b), g);
		end
		m = n_tmo;
		xfer(0, 8'h42);
		tick(40);
		ack_seen = 1'b1;
		tick(1);
		ack_seen = 1'b0;
		tick(200);
		check("ack stop", m, n_tmo);
		m = n_rcvd;
		k = n_nex;
		rst_req = 1'b1;
		tick(6);
		rst_req = 1'b0;
		tick(4);
		check("reset rcvd", m + 1, n_rcvd);
		check("reset loss", k + 1, n_nex);
		check("aut present", 1, pres);
		check("drv present", 1, dpres);
		fr = frame(8'h96, 1'b0);
		for (int i = 0; i < 10; i++) begin
			link2.aut_txd = fr[i];
			tick(32);
		end
		link2.aut_txd = 1'b1;
		tick(64);
		check("stop err", 1, n_err2);
		check("err data", 0, n_rx2);
		link2.sense_aut = 1'b0;
		tick(6);
		check("sense loss", 1, n_nex2);
		check("absent", 0, pres2);
		check("link errs", 0, n_err);
		// ip variant keeps its fixed time-out after rate changes
		tx_v2 = 1'b1;
		tick(1);
		tx_v2 = 1'b0;
		t0 = cyc;
		tick(exp_gap(32, IP_T) + 8);
		check("ip ack gap", exp_gap(32, IP_T), tmo2_at - t0);
		close_out();
	end
endmodule
`default_nettype wire
